// ### src/divsync_pkg.sv
// Shared constants for the divider alignment device and its controller.
// Assumes both ends run on one clock and meet through divsync_if.
package divsync_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam logic [8:0] SIGHI_ADDR = 9'h025;
	localparam logic [8:0] DITHER_ADDR = 9'h030;
	localparam logic [8:0] ALIGN_ADDR = 9'h100;
	localparam logic [8:0] OUTMODE_ADDR = 9'h014;
	localparam int MASTER_BIT = 0;
	localparam int DIVSYNC_BIT = 1;
	localparam int FIRSTONLY_BIT = 2;
	localparam int DITHER_BIT = 4;
	localparam int OUTTYPE_BIT = 6;
	localparam logic [7:0] ALIGN_RST = 8'h00;
	localparam logic [7:0] DITHER_RST = 8'h00;
	localparam logic [7:0] OUTMODE_RST = 8'h00;
	localparam logic [7:0] SIGHI_RST = 8'h00;
	localparam logic [7:0] ALIGN_MASK = 8'h07;
	localparam logic [7:0] DITHER_MASK = 8'h10;
	localparam logic [7:0] OUTMODE_MASK = 8'h40;
	// Controller register offsets, byte addressed
	localparam logic [3:0] C_CMD = 4'h0;
	localparam logic [3:0] C_STAT = 4'h4;
	localparam logic [3:0] C_PINS = 4'h8;
	localparam logic [8:0] C_ADDR_LSB = 9'h010;
	// Command word fields and pin register bits
	localparam int CMD_RD_BIT = 16;
	localparam int CMD_WD_LSB = 17;
	localparam int PIN_SYNC_BIT = 0;
	localparam int PIN_DIS_BIT = 1;
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage : divsync_pkg

// ### src/divsync_if.sv
// Link between the converter's configuration port and its controller.
// Assumes one shared clock; register access is a one-cycle strobe.
interface divsync_if;
	logic [8:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic rvalid;
	logic sync_pulse;
	logic output_disable_pin;
	modport dev (input addr, wdata, wr, rd, sync_pulse, output_disable_pin,
		output rdata, rvalid);
	modport host (output addr, wdata, wr, rd, sync_pulse, output_disable_pin,
		input rdata, rvalid);
endinterface : divsync_if

// ### src/divsync_dev.sv
// Converter side: alignment control, dither, output type, output disable.
// Assumes the controller drives the link on clk_i; pins pass two flops.
// Functional notes
// - Master enable gates every alignment function
// - Host keeps master off when unused
// - Pulses reach divider only with both enables
// - First-pulse-only aligns once, ignores later pulses
// - Divider enable self-clears after one-shot alignment
// - Output type resets to CMOS
// - Host programs LVDS after power-up
// - Outputs disabled while disable pin high
// - System lowers disable pin after LVDS set
// - Host keeps control port idle when sampling
module divsync_dev import divsync_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	divsync_if.dev link,
	// Converter side
	input wire logic [15:0] selftest_sig_i,
	output logic divider_align_o,
	output logic dither_en_o,
	output logic lvds_sel_o,
	output logic outputs_en_o,
	output logic sync_power_o
);
	typedef struct packed {
		logic [7:0] align;
		logic [7:0] dither;
		logic [7:0] outmode;
		logic [7:0] rdata;
		logic rvalid;
		logic pulse_m;
		logic pulse_s;
		logic pulse_p;
		logic dis_m;
		logic dis_s;
		logic align_p;
		logic armed;
	} dev_state_t;
	dev_state_t s_q, s_d;
	logic rise;
	always_comb begin
		s_d = s_q;
		s_d.pulse_m = link.sync_pulse;
		s_d.pulse_s = s_q.pulse_m;
		s_d.pulse_p = s_q.pulse_s;
		s_d.dis_m = link.output_disable_pin;
		s_d.dis_s = s_q.dis_m;
		s_d.rvalid = link.rd;
		s_d.align_p = 1'b0;
		rise = s_q.pulse_s & ~s_q.pulse_p;
		if (link.wr) begin
			unique case (link.addr)
				ALIGN_ADDR: begin
					s_d.align = link.wdata & ALIGN_MASK;
					s_d.armed = 1'b1;
				end
				DITHER_ADDR: s_d.dither = link.wdata & DITHER_MASK;
				OUTMODE_ADDR: s_d.outmode = link.wdata & OUTMODE_MASK;
				default: ;
			endcase
		end
		if (rise && s_q.align[MASTER_BIT] && s_q.align[DIVSYNC_BIT]) begin
			if (s_q.align[FIRSTONLY_BIT]) begin
				if (s_q.armed) begin
					s_d.align_p = 1'b1;
					s_d.armed = 1'b0;
					if (!(link.wr && link.addr == ALIGN_ADDR))
						s_d.align[DIVSYNC_BIT] = 1'b0;
				end
			end else begin
				s_d.align_p = 1'b1;
			end
		end
		s_d.rdata = 8'h00;
		if (link.rd) begin
			unique case (link.addr)
				ALIGN_ADDR: s_d.rdata = s_q.align;
				DITHER_ADDR: s_d.rdata = s_q.dither;
				OUTMODE_ADDR: s_d.rdata = s_q.outmode;
				SIGHI_ADDR: s_d.rdata = selftest_sig_i[15:8];
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (rst_i) begin
			s_d = '0;
			s_d.align = ALIGN_RST;
			s_d.dither = DITHER_RST;
			s_d.outmode = OUTMODE_RST;
			s_d.dis_m = 1'b1;
			s_d.dis_s = 1'b1;
			s_d.armed = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		s_q <= s_d;
	end
	assign link.rdata = s_q.rdata;
	assign link.rvalid = s_q.rvalid;
	assign divider_align_o = s_q.align_p;
	assign dither_en_o = s_q.dither[DITHER_BIT];
	assign lvds_sel_o = s_q.outmode[OUTTYPE_BIT];
	assign outputs_en_o = ~s_q.dis_s;
	assign sync_power_o = s_q.align[MASTER_BIT];
endmodule : divsync_dev

// ### src/divsync_ctl.sv
// Controller side: Wishbone slave turning software orders into link access.
// Assumes a classic Wishbone master on the same clock.
module divsync_ctl import divsync_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	divsync_if.host link
);
	typedef enum logic [1:0] {IDLE, WAIT, DONE} ctl_st_t;
	typedef struct packed {
		ctl_st_t st;
		logic [8:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic [7:0] rdata;
		logic sync;
		logic dis;
		logic ack;
		logic [31:0] dat;
	} ctl_state_t;
	ctl_state_t s_q, s_d;
	logic req;
	always_comb begin
		s_d = s_q;
		s_d.wr = 1'b0;
		s_d.rd = 1'b0;
		s_d.ack = 1'b0;
		req = cyc_i & stb_i & ~s_q.ack;
		unique case (s_q.st)
			IDLE: if (req) begin
				s_d.ack = 1'b1;
				s_d.dat = UNMAPPED_RD;
				unique case (adr_i)
					C_CMD: if (we_i && sel_i[0]) begin
						// Address, read flag, then write data
						s_d.addr = dat_i[ADDR_W-1:0];
						s_d.wdata = dat_i[CMD_WD_LSB +: DATA_W];
						s_d.wr = ~dat_i[CMD_RD_BIT];
						s_d.rd = dat_i[CMD_RD_BIT];
						if (dat_i[CMD_RD_BIT]) begin
							s_d.ack = 1'b0;
							s_d.st = WAIT;
						end
					end
					C_STAT: s_d.dat = {24'h000000, s_q.rdata};
					C_PINS: begin
						if (we_i && sel_i[0]) begin
							s_d.sync = dat_i[PIN_SYNC_BIT];
							s_d.dis = dat_i[PIN_DIS_BIT];
						end
						s_d.dat = {30'h0, s_q.dis, s_q.sync};
					end
					default: ;
				endcase
			end
			WAIT: if (link.rvalid) begin
				s_d.rdata = link.rdata;
				s_d.dat = {24'h000000, link.rdata};
				s_d.ack = 1'b1;
				s_d.st = DONE;
			end
			DONE: s_d.st = IDLE;
			default: s_d.st = IDLE;
		endcase
		if (rst_i) begin
			s_d = '0;
			s_d.st = IDLE;
			s_d.dis = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		s_q <= s_d;
	end
	assign dat_o = s_q.dat;
	assign ack_o = s_q.ack;
	assign link.addr = s_q.addr;
	assign link.wdata = s_q.wdata;
	assign link.wr = s_q.wr;
	assign link.rd = s_q.rd;
	assign link.sync_pulse = s_q.sync;
	assign link.output_disable_pin = s_q.dis;
endmodule : divsync_ctl

// ### tb/divsync_sva.sv
// Checker for the link and the converter-side outputs.
// Assumes one clock; instantiated beside the link in the bench.
module divsync_sva (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Watched signals
	input wire logic rd,
	input wire logic rvalid,
	input wire logic sync_pulse,
	input wire logic output_disable_pin,
	input wire logic divider_align_o,
	input wire logic sync_power_o,
	input wire logic outputs_en_o,
	input wire logic lvds_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_MASTER: assert property (divider_align_o |-> $past(sync_power_o))
		else $error("align without master");
	AST_SRC: assert property (divider_align_o |-> $past(sync_pulse, 3))
		else $error("align without pulse");
	AST_ONE: assert property (divider_align_o |=> !divider_align_o)
		else $error("align too long");
	AST_CMOS: assert property ($fell(rst_i) |-> !lvds_sel_o)
		else $error("not cmos");
	AST_OFF: assert property (output_disable_pin [*4] |-> !outputs_en_o)
		else $error("outputs on");
	AST_ON: assert property (!output_disable_pin [*4] |-> outputs_en_o)
		else $error("outputs off");
	AST_RV: assert property (rd |=> rvalid)
		else $error("no rvalid");
	AST_RV_SRC: assert property (rvalid |-> $past(rd))
		else $error("stray rvalid");
	cover property (divider_align_o);
	cover property (rd ##1 rvalid);
	cover property ($rose(lvds_sel_o));
endmodule : divsync_sva

// ### tb/divider_sync_control_tb.sv
// Bench: both ends joined, driven over Wishbone.
// Assumes the controller command word {data, read flag, address}.
module divider_sync_control_tb;
	import divsync_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, al, dit, lv, oe, pw;
	logic [3:0] adr = 0;
	logic [31:0] dat = 0, dq, q;
	logic [7:0] n_al = 0;
	int failures = 0, num_checks = 0;
	always #2.5 clk_i = ~clk_i;
	divsync_if lk();
	divsync_dev i_divsync_dev (.clk_i(clk_i), .rst_i(rst_i), .link(lk.dev),
		.selftest_sig_i(16'hA55A), .divider_align_o(al), .dither_en_o(dit),
		.lvds_sel_o(lv), .outputs_en_o(oe), .sync_power_o(pw));
	divsync_ctl i_divsync_ctl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
		.dat_o(dq), .ack_o(ack), .link(lk.host));
	divsync_sva i_divsync_sva (.clk_i(clk_i), .rst_i(rst_i), .rd(lk.rd),
		.rvalid(lk.rvalid), .sync_pulse(lk.sync_pulse),
		.output_disable_pin(lk.output_disable_pin), .divider_align_o(al),
		.sync_power_o(pw), .outputs_en_o(oe), .lvds_sel_o(lv));
	always @(posedge clk_i) if (al === 1'b1) n_al <= n_al + 8'h01;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		q = dq;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask : wb
	task automatic dw(input logic [8:0] a, input logic [7:0] v);
		wb(1, C_CMD, {7'h00, v, 1'b0, 7'h00, a});
	endtask : dw
	task automatic dr(input logic [8:0] a, input logic [7:0] e);
		wb(1, C_CMD, {15'h0000, 1'b1, 7'h00, a});
		chk(q[7:0], e);
	endtask : dr
	task automatic pulses(input logic [8:0] cfg, input int k, input logic [7:0] e);
		logic [7:0] base;
		base = n_al;
		dw(ALIGN_ADDR, cfg[7:0]);
		repeat (k) begin
			wb(1, C_PINS, 32'h0000_0003);
			wb(1, C_PINS, 32'h0000_0002);
			repeat (6) @(posedge clk_i);
		end
		chk(n_al - base, e);
	endtask : pulses
	task automatic wrap_up;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(lv, 0);
		chk(oe, 0);
		dr(ALIGN_ADDR, ALIGN_RST);
		dw(SIGHI_ADDR, 8'h3C);
		dr(SIGHI_ADDR, 8'hA5);
		wb(0, 4'hC, 32'h0);
		chk(q[7:0], 8'h00);
		pulses(9'h000, 1, 0);
		pulses(9'h002, 1, 0);
		pulses(9'h001, 1, 0);
		pulses(9'h003, 2, 2);
		chk(pw, 1);
		dr(ALIGN_ADDR, 8'h03);
		pulses(9'h007, 2, 1);
		dr(ALIGN_ADDR, 8'h05);
		dw(DITHER_ADDR, 8'h10);
		dr(DITHER_ADDR, 8'h10);
		wb(0, C_STAT, 32'h0);
		chk(q[7:0], 8'h10);
		chk(dit, 1);
		dw(OUTMODE_ADDR, 8'h40);
		chk(lv, 1);
		dr(OUTMODE_ADDR, 8'h40);
		wb(1, C_PINS, 32'h0);
		repeat (6) @(posedge clk_i);
		chk(oe, 1);
		wb(0, C_PINS, 32'h0);
		chk(q[7:0], 8'h00);
		dw(ALIGN_ADDR, 8'h00);
		chk(pw, 0);
		wrap_up();
	end
endmodule : divider_sync_control_tb
